// File: gen_ctrl_pkg.sv
package gen_ctrl_pkg;

    // ------------------------------------------------------------
    // Register location and reset value
    // ------------------------------------------------------------
    localparam logic [7:0]  GEN_CTRL_OFFSET = 8'hD4;
    localparam logic [31:0] GEN_CTRL_RESET  = 32'h8206C000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RETRY_MSB   = 31;
    localparam int RETRY_LSB   = 30;
    localparam int RSVD_MSB    = 29;
    localparam int RSVD_LSB    = 28;
    localparam int LOW_SWING   = 27;
    localparam int PM_SEL      = 26;
    localparam int STRICT_PRIO = 25;
    localparam int FORCE_RM    = 24;
    localparam int LPM_DEF     = 23;
    localparam int SHORT_MSB   = 22;
    localparam int SHORT_LSB   = 20;

    // Bits this block owns; 19:0 belong elsewhere
    localparam logic [31:0] WRITE_MASK = 32'hCFF00000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] RETRY_25US = 2'h0;
    localparam logic [1:0] RETRY_1MS  = 2'h1;
    localparam logic [1:0] RETRY_25MS = 2'h2;
    localparam logic [1:0] RETRY_50MS = 2'h3;

    localparam logic [2:0] SHORT_IGNORE   = 3'h0;
    localparam logic [2:0] SHORT_PIN      = 3'h1;
    localparam logic [2:0] SHORT_CLKSTOP  = 3'h2;
    localparam logic [2:0] SHORT_BOTH     = 3'h3;
    localparam logic [2:0] SHORT_UNSUPP   = 3'h4;

    localparam logic [2:0] PM_REV_OLD     = 3'h2;
    localparam logic [2:0] PM_REV_NEW     = 3'h3;
    localparam logic [2:0] LOWPRI_CNT_DEF = 3'h1;
    localparam logic [2:0] LOWPRI_STRICT  = 3'h0;
    localparam logic [1:0] LPM_OFF        = 2'h0;
    localparam logic [1:0] LPM_BOTH       = 2'h3;

    // ------------------------------------------------------------
    // Retry timeout in cycles of the 50 MHz clock
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 50;
    localparam int RETRY_25US_US  = 25;
    localparam int RETRY_1MS_US   = 1000;
    localparam int RETRY_25MS_US  = 25000;
    localparam int RETRY_50MS_US  = 50000;
    localparam int RETRY_25US_CYC = RETRY_25US_US * CLK_MHZ;
    localparam int RETRY_1MS_CYC  = RETRY_1MS_US * CLK_MHZ;
    localparam int RETRY_25MS_CYC = RETRY_25MS_US * CLK_MHZ;
    localparam int RETRY_50MS_CYC = RETRY_50MS_US * CLK_MHZ;

    // Decoded controls handed to the rest of the bridge
    typedef struct packed {
        logic       tx_low_swing;
        logic       read_multiple_force;
        logic       strict_grant;
        logic [2:0] pm_revision_field;
        logic       pm_state_retain;
        logic [2:0] low_prio_count_default;
        logic [1:0] link_pm_ctrl_field;
    } ctrl_out_type;

endpackage

// File: bridge_general_control.sv
`timescale 1ns/1ps

module bridge_general_control (
    // Clock and resets
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       global_reset_pin,
    input  wire logic                       power_on_reset,
    // Configuration access
    input  wire logic                       cfg_wr,
    input  wire logic                       cfg_rd,
    input  wire logic [7:0]                 cfg_addr,
    input  wire logic [3:0]                 cfg_be,
    input  wire logic [31:0]                cfg_wdata,
    output logic      [31:0]                cfg_rdata,
    output logic                            cfg_rd_hit,
    // Retry timer on the secondary bus
    input  wire logic                       retry_start,
    input  wire logic                       retry_done,
    output logic                            retry_expired,
    // Slot power and transaction screening
    input  wire logic                       slot_power_short,
    input  wire logic                       txn_valid,
    input  wire logic                       txn_is_cfg,
    input  wire logic                       txn_is_spl_msg,
    input  wire logic [2:0]                 low_prio_count,
    output logic                            power_shortfall_pin,
    output logic                            sec_clk_stop,
    output logic                            txn_unsupported,
    // Decoded controls
    output gen_ctrl_pkg::ctrl_out_type      ctrl
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [31:0] reg_q, reg_d;
    logic        any_rst;
    logic        hit;
    logic [31:0] be_mask;

    assign any_rst = rst | global_reset_pin | power_on_reset;
    assign hit     = cfg_addr == gen_ctrl_pkg::GEN_CTRL_OFFSET;
    assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

    always_comb begin
        reg_d = reg_q;
        if (cfg_wr && hit) begin
            // Only owned bits change; reserved 29:28 stay zero
            reg_d = (reg_q & ~(be_mask & gen_ctrl_pkg::WRITE_MASK))
                  | (cfg_wdata & be_mask & gen_ctrl_pkg::WRITE_MASK);
        end
    end

    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            reg_q <= gen_ctrl_pkg::GEN_CTRL_RESET & gen_ctrl_pkg::WRITE_MASK;
        end else begin
            reg_q <= reg_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] rdata_d;
    logic        rd_hit_d;

    always_comb begin
        rdata_d  = 32'h00000000;
        rd_hit_d = cfg_rd && hit;
        if (rd_hit_d) begin
            rdata_d = reg_q & gen_ctrl_pkg::WRITE_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            cfg_rdata  <= 32'h00000000;
            cfg_rd_hit <= 1'b0;
        end else begin
            cfg_rdata  <= rdata_d;
            cfg_rd_hit <= rd_hit_d;
        end
    end

    // ------------------------------------------------------------
    // Retry timeout counter
    // ------------------------------------------------------------
    logic [1:0]  retry_sel;
    logic [21:0] retry_limit;
    logic [21:0] retry_cnt_q, retry_cnt_d;
    logic        retry_run_q, retry_run_d;
    logic        retry_exp_d;

    assign retry_sel = reg_q[gen_ctrl_pkg::RETRY_MSB:gen_ctrl_pkg::RETRY_LSB];

    always_comb begin
        case (retry_sel)
            gen_ctrl_pkg::RETRY_25US: retry_limit = 22'(gen_ctrl_pkg::RETRY_25US_CYC);
            gen_ctrl_pkg::RETRY_1MS:  retry_limit = 22'(gen_ctrl_pkg::RETRY_1MS_CYC);
            gen_ctrl_pkg::RETRY_25MS: retry_limit = 22'(gen_ctrl_pkg::RETRY_25MS_CYC);
            default:                  retry_limit = 22'(gen_ctrl_pkg::RETRY_50MS_CYC);
        endcase
    end

    always_comb begin
        retry_cnt_d = retry_cnt_q;
        retry_run_d = retry_run_q;
        retry_exp_d = 1'b0;
        if (retry_start) begin
            retry_cnt_d = 22'h000000;
            retry_run_d = 1'b1;
        end else if (retry_done) begin
            retry_run_d = 1'b0;
        end else if (retry_run_q) begin
            if (retry_cnt_q + 22'h000001 >= retry_limit) begin
                // Upstream completes with retry status
                retry_exp_d = 1'b1;
                retry_run_d = 1'b0;
            end
            retry_cnt_d = retry_cnt_q + 22'h000001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            retry_cnt_q   <= 22'h000000;
            retry_run_q   <= 1'b0;
            retry_expired <= 1'b0;
        end else begin
            retry_cnt_q   <= retry_cnt_d;
            retry_run_q   <= retry_run_d;
            retry_expired <= retry_exp_d;
        end
    end

    // ------------------------------------------------------------
    // Slot power shortfall and decoded controls
    // ------------------------------------------------------------
    logic [2:0]                 short_act;
    logic                       pin_d, clk_stop_d, unsupp_d;
    gen_ctrl_pkg::ctrl_out_type ctrl_d;

    assign short_act = reg_q[gen_ctrl_pkg::SHORT_MSB:gen_ctrl_pkg::SHORT_LSB];

    always_comb begin
        pin_d      = 1'b0;
        clk_stop_d = 1'b0;
        unsupp_d   = 1'b0;
        if (slot_power_short) begin
            // Reserved codes fall to default and do nothing
            case (short_act)
                gen_ctrl_pkg::SHORT_PIN:     pin_d = 1'b1;
                gen_ctrl_pkg::SHORT_CLKSTOP: clk_stop_d = 1'b1;
                gen_ctrl_pkg::SHORT_BOTH: begin
                    pin_d      = 1'b1;
                    clk_stop_d = 1'b1;
                end
                gen_ctrl_pkg::SHORT_UNSUPP:
                    unsupp_d = txn_valid && !txn_is_cfg && !txn_is_spl_msg;
                default: ;
            endcase
        end
    end

    always_comb begin
        ctrl_d.tx_low_swing        = reg_q[gen_ctrl_pkg::LOW_SWING];
        ctrl_d.read_multiple_force = reg_q[gen_ctrl_pkg::FORCE_RM];
        ctrl_d.strict_grant        = reg_q[gen_ctrl_pkg::STRICT_PRIO]
                                   && low_prio_count == gen_ctrl_pkg::LOWPRI_STRICT;
        ctrl_d.pm_revision_field   = reg_q[gen_ctrl_pkg::PM_SEL] ? gen_ctrl_pkg::PM_REV_NEW
                                                                 : gen_ctrl_pkg::PM_REV_OLD;
        ctrl_d.pm_state_retain     = reg_q[gen_ctrl_pkg::PM_SEL];
        ctrl_d.low_prio_count_default = reg_q[gen_ctrl_pkg::STRICT_PRIO]
                                      ? gen_ctrl_pkg::LOWPRI_STRICT
                                      : gen_ctrl_pkg::LOWPRI_CNT_DEF;
        ctrl_d.link_pm_ctrl_field  = reg_q[gen_ctrl_pkg::LPM_DEF] ? gen_ctrl_pkg::LPM_BOTH
                                                                  : gen_ctrl_pkg::LPM_OFF;
    end

    always_ff @(posedge core_clk) begin
        if (any_rst) begin
            power_shortfall_pin <= 1'b0;
            sec_clk_stop        <= 1'b0;
            txn_unsupported     <= 1'b0;
            ctrl                <= '0;
        end else begin
            power_shortfall_pin <= pin_d;
            sec_clk_stop        <= clk_stop_d;
            txn_unsupported     <= unsupp_d;
            ctrl                <= ctrl_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_reset_value: assert property (@(posedge core_clk)
        $past(any_rst) |-> reg_q == (gen_ctrl_pkg::GEN_CTRL_RESET & gen_ctrl_pkg::WRITE_MASK))
        else $error("register not at reset value");
    a_rsvd_zero: assert property (@(posedge core_clk) disable iff (any_rst)
        cfg_rdata[29:28] == 2'h0) else $error("reserved bits read nonzero");
    a_write_back: assert property (@(posedge core_clk) disable iff (any_rst)
        cfg_wr && hit && cfg_be == 4'hF |=> reg_q[31:30] == $past(cfg_wdata[31:30])
        && reg_q[27:20] == $past(cfg_wdata[27:20])) else $error("write not stored");
    // Outputs hold zero through the reset edge, so only judge cycles begun out of reset
    a_low_swing: assert property (@(posedge core_clk) disable iff (any_rst)
        !any_rst |=> ctrl.tx_low_swing == $past(reg_q[27])) else $error("low swing mismatch");
    a_pm_rev: assert property (@(posedge core_clk) disable iff (any_rst)
        !any_rst |=> ctrl.pm_revision_field == ($past(reg_q[26]) ? 3'h3 : 3'h2))
        else $error("pm revision wrong");
    a_strict_grant: assert property (@(posedge core_clk) disable iff (any_rst)
        !any_rst && reg_q[25] && low_prio_count == 3'h0 |=> ctrl.strict_grant)
        else $error("strict grant missing");
    a_lowprio_def: assert property (@(posedge core_clk) disable iff (any_rst)
        !any_rst |=> ctrl.low_prio_count_default == ($past(reg_q[25]) ? 3'h0 : 3'h1))
        else $error("low priority default wrong");
    a_force_rm: assert property (@(posedge core_clk) disable iff (any_rst)
        !any_rst |=> ctrl.read_multiple_force == $past(reg_q[24]))
        else $error("force mismatch");
    a_link_pm: assert property (@(posedge core_clk) disable iff (any_rst)
        !any_rst |=> ctrl.link_pm_ctrl_field == ($past(reg_q[23]) ? 2'h3 : 2'h0))
        else $error("link pm default wrong");
    a_short_pin: assert property (@(posedge core_clk) disable iff (any_rst)
        slot_power_short && (short_act == 3'h1 || short_act == 3'h3) |=> power_shortfall_pin)
        else $error("shortfall pin not driven");
    a_unsupp: assert property (@(posedge core_clk) disable iff (any_rst)
        txn_unsupported |-> $past(txn_valid && !txn_is_cfg && !txn_is_spl_msg
        && short_act == 3'h4 && slot_power_short)) else $error("bad unsupported");
    a_retry_25us: assert property (@(posedge core_clk) disable iff (any_rst)
        retry_start && retry_sel == 2'h0 ##1 (!retry_start && !retry_done && retry_sel == 2'h0)[*8]
        |-> !retry_expired) else $error("retry expired early");

endmodule

// File: cfg_host.sv
`timescale 1ns/1ps
module cfg_host (
    // Clock
    input  wire logic        core_clk,
    // Configuration access
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rd_hit
);
    // ------------------------------------------------------------
    // Host side of configuration accesses
    // ------------------------------------------------------------
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // Idle bus shows inverted values so a stale sample never matches
    task automatic idle(input logic [7:0] a, input logic [31:0] d);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge core_clk);
        if (d[22:20] > 3'h4) d[22] = 1'b0;
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge core_clk);
        idle(a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic hit);
        @(posedge core_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge core_clk);
        idle(a, 32'h0);
        #1;
        d = cfg_rdata;
        hit = cfg_rd_hit;
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                       core_clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       global_reset_pin = 1'b0;
    logic                       power_on_reset = 1'b0;
    logic                       retry_start = 1'b0;
    logic                       retry_done = 1'b0;
    logic                       slot_power_short = 1'b0;
    logic                       txn_valid = 1'b0;
    logic                       txn_is_cfg = 1'b0;
    logic                       txn_is_spl_msg = 1'b0;
    logic [2:0]                 low_prio_count = 3'h0;
    logic                       cfg_wr, cfg_rd, cfg_rd_hit, retry_expired;
    logic [7:0]                 cfg_addr;
    logic [3:0]                 cfg_be;
    logic [31:0]                cfg_wdata, cfg_rdata;
    logic                       power_shortfall_pin, sec_clk_stop, txn_unsupported;
    gen_ctrl_pkg::ctrl_out_type ctrl;
    int                         checks = 0;
    int                         mismatches = 0;
    int                         cycles = 0;
    localparam logic [31:0]     RST_READ = gen_ctrl_pkg::GEN_CTRL_RESET & gen_ctrl_pkg::WRITE_MASK;

    always #10 core_clk = ~core_clk;

    cfg_host host (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_hit(cfg_rd_hit));

    bridge_general_control DUT (.core_clk(core_clk), .rst(rst),
        .global_reset_pin(global_reset_pin), .power_on_reset(power_on_reset),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_hit(cfg_rd_hit),
        .retry_start(retry_start), .retry_done(retry_done), .retry_expired(retry_expired),
        .slot_power_short(slot_power_short), .txn_valid(txn_valid), .txn_is_cfg(txn_is_cfg),
        .txn_is_spl_msg(txn_is_spl_msg), .low_prio_count(low_prio_count),
        .power_shortfall_pin(power_shortfall_pin), .sec_clk_stop(sec_clk_stop),
        .txn_unsupported(txn_unsupported), .ctrl(ctrl));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp, input logic hit_exp);
        logic [31:0] d;
        logic        h;
        host.rd(a, d, h);
        check({31'h0, h}, {31'h0, hit_exp});
        check(d, exp);
    endtask
    task automatic chk_ctrl(input logic sw, rm, g, pm, input logic [2:0] def, input logic lpm);
        gen_ctrl_pkg::ctrl_out_type e;
        e = '{sw, rm, g, pm ? gen_ctrl_pkg::PM_REV_NEW : gen_ctrl_pkg::PM_REV_OLD, pm, def,
              lpm ? gen_ctrl_pkg::LPM_BOTH : gen_ctrl_pkg::LPM_OFF};
        check({20'h0, ctrl}, {20'h0, e});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state();
        tick(2);
        read_chk(gen_ctrl_pkg::GEN_CTRL_OFFSET, RST_READ, 1'b1);
        chk_ctrl(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0);
    endtask
    task automatic t_fields();
        host.wr(8'hD4, 4'hF, 32'hFFB00000);
        tick(2);
        read_chk(8'hD4, 32'hCFB00000, 1'b1);
        chk_ctrl(1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b1);
        low_prio_count <= 3'h1;
        tick(2);
        chk_ctrl(1'b1, 1'b1, 1'b0, 1'b1, 3'h0, 1'b1);
        low_prio_count <= 3'h0;
        host.wr(8'hD4, 4'h7, 32'h0);
        read_chk(8'hD4, 32'hCF000000, 1'b1);
        host.wr(8'hD4, 4'hF, 32'h0);
        tick(2);
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 1'b0);
        read_chk(8'hD0, 32'h0, 1'b0);
    endtask
    task automatic t_shortfall();
        slot_power_short <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            host.wr(8'hD4, 4'hF, 32'(c) << 20);
            tick(3);
            check({30'h0, power_shortfall_pin, sec_clk_stop},
                  {30'h0, c == 1 || c == 3, c == 2 || c == 3});
        end
        for (int k = 0; k < 4; k++) begin
            slot_power_short <= (k != 3);
            txn_valid <= 1'b1;
            txn_is_cfg <= (k == 1);
            txn_is_spl_msg <= (k == 2);
            tick(1);
            txn_valid <= 1'b0;
            check({31'h0, txn_unsupported}, {31'h0, k == 0});
            tick(1);
        end
    endtask
    task automatic t_retry();
        int   n;
        logic seen;
        host.wr(8'hD4, 4'hF, 32'h0);
        @(posedge core_clk);
        retry_start <= 1'b1;
        @(posedge core_clk);
        retry_start <= 1'b0;
        n = 0;
        while (n < 1400 && retry_expired !== 1'b1) begin
            tick(1);
            n++;
        end
        check(32'(n), 32'(gen_ctrl_pkg::RETRY_25US_CYC));
        retry_start <= 1'b1;
        @(posedge core_clk);
        retry_start <= 1'b0;
        tick(100);
        retry_done <= 1'b1;
        @(posedge core_clk);
        retry_done <= 1'b0;
        seen = 1'b0;
        repeat (1300) begin
            tick(1);
            seen |= retry_expired;
        end
        check({31'h0, seen}, 32'h0);
    endtask
    task automatic t_other_resets();
        for (int w = 0; w < 3; w++) begin
            host.wr(8'hD4, 4'hF, 32'h4DB00000);
            read_chk(8'hD4, 32'h4DB00000, 1'b1);
            global_reset_pin <= (w == 0);
            power_on_reset <= (w == 1);
            rst <= (w == 2);
            tick(2);
            global_reset_pin <= 1'b0;
            power_on_reset <= 1'b0;
            rst <= 1'b0;
            t_reset_state();
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_state();
        t_fields();
        t_shortfall();
        t_retry();
        t_other_resets();
        test_done();
    end
endmodule
